// ==== hdl/spi_port_pkg.sv ====
// Constants and types shared by the SPI port design files
package spi_port_pkg;
	localparam int DATA_W = 8;
	localparam int CNT_W = 4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] RATE_DIV4 = 2'h0;
	localparam logic [1:0] RATE_DIV8 = 2'h1;
	localparam logic [1:0] RATE_DIV16 = 2'h2;
	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV8 = 6'h04;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV32 = 6'h10;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LEAD = 3'b010,
		ST_TRAIL = 3'b100
	} xfer_state_t;
endpackage

// ==== hdl/spi_tick_if.sv ====
// Half bit-slot tick carrier between the rate divider and the SPI core
`timescale 1ns/10ps
interface spi_tick_if;
	logic [1:0] rate;
	logic timer_sel;
	logic timer_ovf;
	logic run;
	logic tick;
	modport gen (input rate, input timer_sel, input timer_ovf, input run, output tick);
	modport core (output rate, output timer_sel, output timer_ovf, output run, input tick);
endinterface

// ==== hdl/spi_rate_gen.sv ====
// Half bit-slot enable generator for the master SCK
`timescale 1ns/10ps
module spi_rate_gen (
	input wire logic clk,
	input wire logic nrst,
	spi_tick_if.gen tk
);
	import spi_port_pkg::*;
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic [5:0] half;
	logic step;

	// Source is the system clock or timer overflow pulses; free running, so a
	// transfer waits for the next half-slot tick
	always_comb begin
		case (tk.rate)
			RATE_DIV4: half = HALF_DIV4;
			RATE_DIV8: half = HALF_DIV8;
			RATE_DIV16: half = HALF_DIV16;
			default: half = HALF_DIV32;
		endcase
		step = tk.timer_sel ? tk.timer_ovf : 1'b1;
		next_cnt = cnt;
		tk.tick = 1'b0;
		if (step) begin
			if (cnt >= half - 6'h01) begin
				next_cnt = 6'h00;
				tk.tick = 1'b1;
			end else begin
				next_cnt = cnt + 6'h01;
			end
		end
		// Held at zero while not master, so a new master starts on a whole slot
		if (!tk.run) begin
			next_cnt = 6'h00;
			tk.tick = 1'b0;
		end
	end

	// Counter register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 6'h00;
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule // spi_rate_gen

// ==== hdl/spi_master_slave_port.sv ====
// Double-buffered SPI port, master or slave, with mode-fault detection
// Contract
// - 4-wire slave responds only while select is low; otherwise passive, MISO off
// - Select going high resets slave shift logic, bit counter, partial byte
// - Select-ignore makes the slave always enabled (3-wire)
// - Slave output disable keeps MISO undriven even when selected
// - Master with select-ignore: select pin has no effect
// - Master without select-ignore: select low clears master-select, SCK and MOSI become inputs
// - Mode fault sets fault flag and requests interrupt if enabled
// - After fault the device stays slave until master-select written one
// - Master data write loads buffer; empty shifter takes it, sets empty flag, starts
// - Master start may wait for the next half bit slot
// - Master shifts MOSI and drives SCK together; samples MISO one clock later
// - Byte end moves received byte to buffer, sets done flag, interrupt
// - Data read returns the last completed received byte
// - Empty flag set when the shifter takes the buffer; cleared by software or data write
// - Byte written while busy waits, then loads at completion and starts
// - Empty flag interrupts only with interrupt and enhanced enables
// - Master-select clear: slave shifts only under master SCK, never starts
// - Slave data preloaded; queued byte loads after each transfer and waits
// - SCK output when master, input when slave; MOSI/MISO direction by mode
// - Byte order LSB-first or MSB-first under software choice
// - Four master bit rates or Timer 1 overflow pacing
// - Clock source select: system clock or timer; rate 00 /4, 01 /8
// - Bit order one selects LSB first, zero MSB first
// - Polarity one idles SCK high, zero idles low
`timescale 1ns/10ps
module spi_master_slave_port (
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire logic PORT_ENABLE_IN,
	input wire logic MASTER_SET_IN,
	input wire logic SELECT_IGNORE_IN,
	input wire logic SLAVE_OUT_DISABLE_IN,
	input wire logic BIT_ORDER_IN,
	input wire logic CLOCK_POLARITY_IN,
	input wire logic CLOCK_PHASE_IN,
	input wire logic TIMER_CLOCK_SELECT_IN,
	input wire logic [1:0] RATE_SELECT_IN,
	input wire logic TIMER_OVF_IN,
	input wire logic IRQ_ENABLE_IN,
	input wire logic ENHANCED_IRQ_ENABLE_IN,
	input wire logic DATA_WRITE_IN,
	input wire logic [spi_port_pkg::DATA_W-1:0] DATA_WDATA_IN,
	input wire logic TX_EMPTY_CLEAR_IN,
	input wire logic DONE_CLEAR_IN,
	input wire logic FAULT_CLEAR_IN,
	input wire logic SCK_IN,
	input wire logic MOSI_IN,
	input wire logic MISO_IN,
	input wire logic SS_N_IN,
	output logic SCK_OUT,
	output logic SCK_OE_OUT,
	output logic MOSI_OUT,
	output logic MOSI_OE_OUT,
	output logic MISO_OUT,
	output logic MISO_OE_OUT,
	output logic MASTER_OUT,
	output logic [spi_port_pkg::DATA_W-1:0] DATA_RDATA_OUT,
	output logic TRANSFER_DONE_FLAG_OUT,
	output logic TX_BUFFER_EMPTY_FLAG_OUT,
	output logic MODE_FAULT_FLAG_OUT,
	output logic BUSY_OUT,
	output logic IRQ_OUT
);
	import spi_port_pkg::*;

	spi_tick_if tk ();
	spi_rate_gen u_rate (.clk(CLK_SYS_IN), .nrst(NRST_IN), .tk(tk.gen));

	// Pin synchronisers: first stage is read only by the second; reset to idle pins
	// (select high, SCK low) so no false select follows reset, nor a false SCK edge while polarity is zero
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic sck_prev;
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sync_a <= 4'h4;
			sync_b <= 4'h4;
			sck_prev <= 1'b0;
		end else begin
			sync_a <= {TIMER_OVF_IN, SS_N_IN, (MASTER_OUT ? MISO_IN : MOSI_IN), SCK_IN};
			sync_b <= sync_a;
			sck_prev <= sync_b[0];
		end
	end
	logic sck_s;
	logic din_s;
	logic ss_n_s;
	assign sck_s = sync_b[0];
	assign din_s = sync_b[1];
	assign ss_n_s = sync_b[2];

	// Bit position for a given count, honouring bit order
	function automatic logic [2:0] bit_pos(input logic [3:0] n, input logic lsb_first);
		bit_pos = lsb_first ? n[2:0] : 3'h7 - n[2:0];
	endfunction

	xfer_state_t state;
	xfer_state_t next_state;
	logic master;
	logic next_master;
	logic [7:0] shifter;
	logic [7:0] next_shifter;
	logic [7:0] txbuf;
	logic [7:0] next_txbuf;
	logic txfull;
	logic next_txfull;
	logic shfull;
	logic next_shfull;
	logic [7:0] rxbuf;
	logic [7:0] next_rxbuf;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic sck_lvl;
	logic next_sck_lvl;
	logic dout;
	logic next_dout;
	logic done_f;
	logic next_done_f;
	logic empty_f;
	logic next_empty_f;
	logic fault_f;
	logic next_fault_f;
	logic slave_sel;
	logic lead_edge;
	logic trail_edge;
	logic byte_end;
	logic fault_ev;
	logic [7:0] txsrc;
	logic late_smp;
	logic next_late_smp;
	logic late_last;
	logic next_late_last;
	logic [2:0] late_pos;
	logic [2:0] next_late_pos;

	assign tk.rate = RATE_SELECT_IN;
	assign tk.timer_sel = TIMER_CLOCK_SELECT_IN;
	assign tk.timer_ovf = sync_b[3];
	assign tk.run = master;

	// Slave selected when select low or ignored
	assign slave_sel = PORT_ENABLE_IN && !master && (SELECT_IGNORE_IN || !ss_n_s);
	// Slave SCK edges; leading edge leaves the idle level
	assign lead_edge = (sck_s != sck_prev) && (sck_s != CLOCK_POLARITY_IN);
	assign trail_edge = (sck_s != sck_prev) && (sck_s == CLOCK_POLARITY_IN);
	// A low select while master without select-ignore is another master
	assign fault_ev = PORT_ENABLE_IN && master && !SELECT_IGNORE_IN && !ss_n_s;
	assign txsrc = DATA_WRITE_IN ? DATA_WDATA_IN : txbuf;

	// Transfer engine next-state logic
	always_comb begin
		next_state = state;
		next_master = master;
		next_shifter = shifter;
		next_txbuf = txbuf;
		next_txfull = txfull;
		next_shfull = shfull;
		next_rxbuf = rxbuf;
		next_cnt = cnt;
		next_sck_lvl = master ? sck_lvl : CLOCK_POLARITY_IN;
		next_late_smp = 1'b0;
		next_late_last = 1'b0;
		next_late_pos = late_pos;
		next_dout = dout;
		next_done_f = done_f;
		next_empty_f = empty_f;
		next_fault_f = fault_f;
		byte_end = 1'b0;
		if (MASTER_SET_IN) begin
			next_master = 1'b1;
		end
		if (DATA_WRITE_IN) begin
			next_txbuf = DATA_WDATA_IN;
			next_txfull = 1'b1;
			next_empty_f = 1'b0;
		end
		if (TX_EMPTY_CLEAR_IN) begin
			next_empty_f = 1'b0;
		end
		if (DONE_CLEAR_IN) begin
			next_done_f = 1'b0;
		end
		if (FAULT_CLEAR_IN) begin
			next_fault_f = 1'b0;
		end
		if (!PORT_ENABLE_IN) begin
			next_state = ST_IDLE;
			next_cnt = 4'h0;
			next_sck_lvl = CLOCK_POLARITY_IN;
		end else if (fault_ev) begin
			next_master = 1'b0;
			next_fault_f = 1'b1;
			next_state = ST_IDLE;
			next_cnt = 4'h0;
			next_sck_lvl = CLOCK_POLARITY_IN;
		end else if (master) begin
			// MISO sync lags two clocks, so the master captures one clock after its edge
			if (late_smp) begin
				next_shifter[late_pos] = din_s;
			end
			byte_end = late_last;
			case (state)
				ST_IDLE: begin
					next_sck_lvl = CLOCK_POLARITY_IN;
					if (!shfull && (txfull || DATA_WRITE_IN)) begin
						next_shifter = txsrc;
						next_shfull = 1'b1;
						next_txfull = 1'b0;
						next_empty_f = 1'b1;
					end else if (shfull && tk.tick && !late_last) begin
						// Start only on a half-slot tick
						next_state = ST_LEAD;
						next_cnt = 4'h0;
						next_dout = shifter[bit_pos(4'h0, BIT_ORDER_IN)];
					end
				end
				ST_LEAD: if (tk.tick) begin
					// Leading SCK edge
					next_sck_lvl = !CLOCK_POLARITY_IN;
					if (!CLOCK_PHASE_IN) begin
						next_late_smp = 1'b1;
						next_late_pos = bit_pos(cnt, BIT_ORDER_IN);
					end else begin
						next_dout = shifter[bit_pos(cnt, BIT_ORDER_IN)];
					end
					next_state = ST_TRAIL;
				end
				ST_TRAIL: if (tk.tick) begin
					// Trailing SCK edge
					next_sck_lvl = CLOCK_POLARITY_IN;
					if (CLOCK_PHASE_IN) begin
						next_late_smp = 1'b1;
						next_late_pos = bit_pos(cnt, BIT_ORDER_IN);
					end
					if (cnt == BITS_PER_BYTE - 4'h1) begin
						// Byte ends once the last late capture has landed
						next_late_last = 1'b1;
						next_state = ST_IDLE;
					end else begin
						next_cnt = cnt + 4'h1;
						if (!CLOCK_PHASE_IN) begin
							next_dout = shifter[bit_pos(cnt + 4'h1, BIT_ORDER_IN)];
						end
						next_state = ST_LEAD;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end else if (!slave_sel) begin
			// Deselected slave drops any partial byte
			next_cnt = 4'h0;
			next_state = ST_IDLE;
			if (!shfull && txfull) begin
				next_shifter = txbuf;
				next_shfull = 1'b1;
				next_txfull = 1'b0;
				next_empty_f = 1'b1;
			end
			next_dout = shifter[bit_pos(4'h0, BIT_ORDER_IN)];
		end else begin
			// Selected slave, clocked only by the master SCK
			next_state = ST_LEAD;
			if (!shfull && (txfull || DATA_WRITE_IN) && cnt == 4'h0) begin
				next_shifter = txsrc;
				next_shfull = 1'b1;
				next_txfull = 1'b0;
				next_empty_f = 1'b1;
			end
			if (cnt == 4'h0 && !CLOCK_PHASE_IN) begin
				next_dout = next_shifter[bit_pos(4'h0, BIT_ORDER_IN)];
			end
			if ((lead_edge && !CLOCK_PHASE_IN) || (trail_edge && CLOCK_PHASE_IN)) begin
				next_shifter[bit_pos(cnt, BIT_ORDER_IN)] = din_s;
				if (cnt == BITS_PER_BYTE - 4'h1) begin
					byte_end = 1'b1;
					next_cnt = 4'h0;
				end else begin
					next_cnt = cnt + 4'h1;
				end
			end
			if (CLOCK_PHASE_IN && lead_edge) begin
				next_dout = shifter[bit_pos(cnt, BIT_ORDER_IN)];
			end
			if (!CLOCK_PHASE_IN && trail_edge && cnt != 4'h0) begin
				next_dout = shifter[bit_pos(cnt, BIT_ORDER_IN)];
			end
		end
		if (byte_end) begin
			next_rxbuf = next_shifter;
			next_done_f = 1'b1;
			next_shfull = 1'b0;
			if (txfull || DATA_WRITE_IN) begin
				// Queued byte loads at once; master restarts without software
				next_shifter = txsrc;
				next_shfull = 1'b1;
				next_txfull = 1'b0;
				next_empty_f = 1'b1;
				next_dout = txsrc[bit_pos(4'h0, BIT_ORDER_IN)];
			end
		end
	end

	// Transfer engine registers
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state <= ST_IDLE;
			master <= 1'b0;
			shifter <= BYTE_RESET;
			txbuf <= BYTE_RESET;
			txfull <= 1'b0;
			shfull <= 1'b0;
			rxbuf <= BYTE_RESET;
			cnt <= 4'h0;
			sck_lvl <= 1'b0;
			dout <= 1'b0;
			done_f <= 1'b0;
			empty_f <= 1'b0;
			fault_f <= 1'b0;
			late_smp <= 1'b0;
			late_last <= 1'b0;
			late_pos <= 3'h0;
		end else begin
			state <= next_state;
			master <= next_master;
			shifter <= next_shifter;
			txbuf <= next_txbuf;
			txfull <= next_txfull;
			shfull <= next_shfull;
			rxbuf <= next_rxbuf;
			cnt <= next_cnt;
			sck_lvl <= next_sck_lvl;
			dout <= next_dout;
			done_f <= next_done_f;
			empty_f <= next_empty_f;
			fault_f <= next_fault_f;
			late_smp <= next_late_smp;
			late_last <= next_late_last;
			late_pos <= next_late_pos;
		end
	end

	// Pin drivers; MOSI released between transfers to let other masters in
	assign SCK_OUT = sck_lvl;
	assign SCK_OE_OUT = PORT_ENABLE_IN && master;
	assign MOSI_OUT = dout;
	// MOSI held one clock past the last edge so the far end samples a driven line
	assign MOSI_OE_OUT = PORT_ENABLE_IN && master && (state != ST_IDLE || late_last);
	assign MISO_OUT = dout;
	assign MISO_OE_OUT = slave_sel && !SLAVE_OUT_DISABLE_IN;
	assign MASTER_OUT = master;
	assign DATA_RDATA_OUT = rxbuf;
	assign TRANSFER_DONE_FLAG_OUT = done_f;
	assign TX_BUFFER_EMPTY_FLAG_OUT = empty_f;
	assign MODE_FAULT_FLAG_OUT = fault_f;
	assign BUSY_OUT = shfull;
	// Buffer-empty interrupt needs the enhanced enable too
	assign IRQ_OUT = IRQ_ENABLE_IN && (done_f || fault_f ||
		(empty_f && ENHANCED_IRQ_ENABLE_IN));

	AST_MISO_OFF: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		SLAVE_OUT_DISABLE_IN |-> !MISO_OE_OUT) else $error("MISO driven while disabled");
	AST_FAULT: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		fault_ev |=> !master && fault_f) else $error("Fault did not demote master");
	AST_STAY_SLAVE: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		!master && !MASTER_SET_IN |=> !master) else $error("Mastership regained alone");
	AST_DONE: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		byte_end |=> done_f && rxbuf == $past(next_rxbuf)) else $error("Byte end lost");
	AST_DESELECT: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		!master && !slave_sel |=> cnt == 4'h0) else $error("Counter not reset");
	AST_WRITE: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		DATA_WRITE_IN && shfull && !byte_end |=> !empty_f) else $error("Write left empty flag");
	AST_IRQ: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		!IRQ_ENABLE_IN |-> !IRQ_OUT) else $error("Interrupt without enable");
	AST_SCK_IDLE: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
		master && state == ST_IDLE && $past(state) == ST_IDLE && $stable(CLOCK_POLARITY_IN)
		|-> SCK_OUT == CLOCK_POLARITY_IN) else $error("SCK not idle level");
endmodule // spi_master_slave_port

// ==== bench/spi_far_end.sv ====
// Far-end SPI model: slave while the port masters, master while the port is slave
`timescale 1ns/10ps
module spi_far_end (
	input wire logic clock_polarity_in,
	input wire logic clock_phase_in,
	input wire logic lsb_in,
	input wire logic sck_in,
	input wire logic din_in,
	output logic sck_out,
	output logic dout_out,
	output logic ss_n_out
);
	logic [7:0] tx_sh = 8'h00;
	logic [7:0] rx_sh = 8'h00;
	logic rel = 1'h1;
	logic ph = 1'h0;
	int k = 0;
	// Released data shows the inverse of its last bit, never a stale copy
	assign dout_out = (lsb_in ? tx_sh[0] : tx_sh[7]) ^ rel;
	// Clock stands at its idle level outside frames
	assign sck_out = clock_polarity_in ^ ph;
	initial ss_n_out = 1'h1;
	// Sample on one edge, shift on the other; no shift before the first sample
	always @(sck_in) begin
		if ((sck_in !== clock_polarity_in) ^ clock_phase_in) begin
			rx_sh = lsb_in ? {din_in, rx_sh[7:1]} : {rx_sh[6:0], din_in};
			k++;
		end else if (k > 0) begin
			tx_sh = lsb_in ? {1'h0, tx_sh[7:1]} : {tx_sh[6:0], 1'h0};
		end
	end
	task automatic load(input logic [7:0] b);
		tx_sh = b;
		k = 0;
		rel = 1'h0;
	endtask
	// Select stays low for the whole frame when the slave is addressed
	task automatic xfer(input logic sel, input int bits);
		ss_n_out = ~sel;
		#64;
		repeat (bits) begin
			ph = 1'h1;
			#64;
			ph = 1'h0;
			#64;
		end
		ss_n_out = 1'h1;
		rel = 1'h1;
	endtask
endmodule // spi_far_end

// ==== bench/spi_master_slave_port_test.sv ====
// Self-checking bench for the SPI port against a far-end model
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module spi_master_slave_port_test;
	import spi_port_pkg::*;
	typedef struct packed {
		logic lsb, clock_polarity, clock_phase, tsel;
		logic [1:0] rate;
		logic [7:0] a, b;
	} row_t;
	logic clk, nrst, en, mset, sig, dis, lsb, clock_polarity, clock_phase, tsel, irq_en, enhanced_irq_enable, dwr, tclr, dclr;
	logic fclr, ss_n_drv, p_sck, p_out, p_ss_n, sck_o, sck_oe, mosi_o, mosi_oe, miso_o;
	logic miso_oe, master, done, tx_buffer_empty_flag, fault, busy, irq, sck_prev;
	logic [1:0] rate, tcnt;
	logic [7:0] wdata, rdata;
	wire sck_l, mosi_l, miso_l, ovf;
	int err_count, compares, run_len, half_len;
	row_t r;
	row_t rows [5] = '{'{1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 8'ha5, 8'h3c},
		'{1'h1, 1'h0, 1'h1, 1'h0, 2'h1, 8'h81, 8'h7e},
		'{1'h0, 1'h1, 1'h0, 1'h0, 2'h2, 8'hc3, 8'h18},
		'{1'h1, 1'h1, 1'h1, 1'h0, 2'h3, 8'h01, 8'hfe},
		'{1'h0, 1'h0, 1'h1, 1'h1, 2'h1, 8'h5a, 8'he7}};
	// Each pin carries whichever party enables it
	assign sck_l = sck_oe ? sck_o : p_sck;
	assign mosi_l = mosi_oe ? mosi_o : p_out;
	assign miso_l = miso_oe ? miso_o : p_out;
	assign ovf = (tcnt == 2'h3);
	spi_master_slave_port DUT (.CLK_SYS_IN(clk), .NRST_IN(nrst), .PORT_ENABLE_IN(en),
		.MASTER_SET_IN(mset), .SELECT_IGNORE_IN(sig), .SLAVE_OUT_DISABLE_IN(dis),
		.BIT_ORDER_IN(lsb), .CLOCK_POLARITY_IN(clock_polarity), .CLOCK_PHASE_IN(clock_phase),
		.TIMER_CLOCK_SELECT_IN(tsel), .RATE_SELECT_IN(rate), .TIMER_OVF_IN(ovf),
		.IRQ_ENABLE_IN(irq_en), .ENHANCED_IRQ_ENABLE_IN(enhanced_irq_enable), .DATA_WRITE_IN(dwr),
		.DATA_WDATA_IN(wdata), .TX_EMPTY_CLEAR_IN(tclr), .DONE_CLEAR_IN(dclr),
		.FAULT_CLEAR_IN(fclr), .SCK_IN(sck_l), .MOSI_IN(mosi_l), .MISO_IN(miso_l),
		.SS_N_IN(ss_n_drv & p_ss_n), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe),
		.MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_oe), .MISO_OUT(miso_o),
		.MISO_OE_OUT(miso_oe), .MASTER_OUT(master), .DATA_RDATA_OUT(rdata),
		.TRANSFER_DONE_FLAG_OUT(done), .TX_BUFFER_EMPTY_FLAG_OUT(tx_buffer_empty_flag),
		.MODE_FAULT_FLAG_OUT(fault), .BUSY_OUT(busy), .IRQ_OUT(irq));
	spi_far_end fe (.clock_polarity_in(clock_polarity), .clock_phase_in(clock_phase), .lsb_in(lsb), .sck_in(sck_l),
		.din_in(master ? mosi_l : miso_l), .sck_out(p_sck), .dout_out(p_out),
		.ss_n_out(p_ss_n));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// Clocks between SCK toggles give the bit rate; timer overflows every 4 clocks
	always @(posedge clk) begin
		if (sck_o !== sck_prev) begin
			half_len <= run_len;
			run_len <= 1;
		end else begin
			run_len <= run_len + 1;
		end
		sck_prev <= sck_o;
		tcnt <= tcnt + 2'h1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Extra idle cycle so the next pulse never lands in the same step
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
		cyc(1);
	endtask
	task automatic wr(input logic [7:0] b);
		wdata = b;
		pulse(dwr);
	endtask
	task automatic wdone();
		for (int i = 0; i < 3000 && done !== 1'h1; i++) cyc(1);
		`CHK(done, 1'h1)
	endtask
	task automatic wrap_up();
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Whole run needs well under 40k clocks
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	initial begin
		{nrst, en, mset, sig, dis, lsb, clock_polarity, clock_phase, tsel, irq_en, enhanced_irq_enable, dwr, tclr, dclr} = '0;
		{fclr, rate, wdata, sck_prev, tcnt, run_len, half_len, err_count, compares} = '0;
		ss_n_drv = 1'h1;
		cyc(4);
		{nrst, en, irq_en} = 3'h7;
		cyc(1);
		`CHK({master, done, tx_buffer_empty_flag, fault, sck_oe, mosi_oe, miso_oe}, 7'h00)
		$display("test reset done");
		foreach (rows[i]) begin
			r = rows[i];
			{lsb, clock_polarity, clock_phase, tsel, rate} = {r.lsb, r.clock_polarity, r.clock_phase, r.tsel, r.rate};
			pulse(mset);
			cyc(4);
			fe.load(r.b);
			wr(r.a);
			`CHK({tx_buffer_empty_flag, busy}, 2'h3)
			wdone();
			`CHK(rdata, r.b)
			`CHK(fe.rx_sh, r.a)
			`CHK(sck_o, r.clock_polarity)
			if (!r.tsel) `CHK(half_len, 2 << r.rate)
			`CHK(irq, 1'h1)
			pulse(dclr);
			`CHK(irq, 1'h0)
			enhanced_irq_enable = 1'h1;
			cyc(1);
			`CHK(irq, 1'h1)
			enhanced_irq_enable = 1'h0;
			pulse(tclr);
			`CHK(tx_buffer_empty_flag, 1'h0)
			$display("row %0d done", i);
		end
		{lsb, clock_polarity, clock_phase, tsel, rate} = '0;
		cyc(4);
		fe.load(8'h96);
		wr(8'h11);
		wr(8'h22);
		`CHK(tx_buffer_empty_flag, 1'h0)
		wdone();
		`CHK(rdata, 8'h96)
		pulse(dclr);
		`CHK({busy, tx_buffer_empty_flag}, 2'h3)
		wdone();
		`CHK(fe.rx_sh, 8'h22)
		pulse(dclr);
		$display("test queued byte done");
		sig = 1'h1;
		ss_n_drv = 1'h0;
		cyc(6);
		`CHK({master, fault}, 2'h2)
		sig = 1'h0;
		cyc(6);
		`CHK({master, sck_oe, mosi_oe}, 3'h0)
		`CHK({fault, irq}, 2'h3)
		ss_n_drv = 1'h1;
		pulse(fclr);
		cyc(4);
		`CHK({master, fault, miso_oe}, 3'h0)
		$display("test mode fault done");
		wr(8'hc9);
		fe.load(8'h6b);
		fe.xfer(1'h1, 8);
		wdone();
		`CHK(rdata, 8'h6b)
		`CHK(fe.rx_sh, 8'hc9)
		pulse(dclr);
		fe.load(8'h35);
		fe.xfer(1'h0, 8);
		cyc(6);
		`CHK(done, 1'h0)
		fe.xfer(1'h1, 3);
		cyc(6);
		fe.load(8'h35);
		fe.xfer(1'h1, 8);
		wdone();
		`CHK(rdata, 8'h35)
		pulse(dclr);
		sig = 1'h1;
		fe.load(8'hd2);
		fe.xfer(1'h0, 8);
		wdone();
		`CHK(rdata, 8'hd2)
		pulse(dclr);
		clock_phase = 1'h1;
		wr(8'h4e);
		fe.load(8'hb1);
		fe.xfer(1'h0, 8);
		wdone();
		`CHK(rdata, 8'hb1)
		`CHK(fe.rx_sh, 8'h4e)
		pulse(dclr);
		clock_phase = 1'h0;
		sig = 1'h0;
		dis = 1'h1;
		ss_n_drv = 1'h0;
		cyc(6);
		`CHK({miso_oe, master, fault}, 3'h0)
		dis = 1'h0;
		cyc(2);
		`CHK(miso_oe, 1'h1)
		ss_n_drv = 1'h1;
		cyc(4);
		pulse(mset);
		`CHK(master, 1'h1)
		$display("test slave done");
		wrap_up();
	end
endmodule // spi_master_slave_port_test
